// File: design/tpps_pkg.sv
// constants of the touch-panel power and pen sequencer
package tpps_pkg;
    // counter width of the scl edge counters
    localparam int CNT_W = 5;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    // rising scl edge indices within a frame
    localparam logic [4:0] RISE_ADDR = 5'h07;
    localparam logic [4:0] RISE_RW = 5'h08;
    localparam logic [4:0] RISE_CMD_LAST = 5'h11;
    localparam logic [4:0] RISE_MACK = 5'h12;
    // falling scl edge indices within a frame
    localparam logic [4:0] FALL_SAMPLE = 5'h07;
    localparam logic [4:0] FALL_CONV = 5'h08;
    localparam logic [4:0] FALL_ADDR_ACK = 5'h08;
    localparam logic [4:0] FALL_RD_HI_FIRST = 5'h09;
    localparam logic [4:0] FALL_RD_HI_LAST = 5'h10;
    localparam logic [4:0] FALL_WR_ACK = 5'h11;
    localparam logic [4:0] FALL_CMD = 5'h12;
    localparam logic [4:0] FALL_RD_LO_FIRST = 5'h12;
    localparam logic [4:0] FALL_RD_LO_LAST = 5'h19;
    localparam logic [4:0] FALL_CONV_END = 5'h15;
    // fixed upper six bits of the slave address
    localparam logic [5:0] ADDR_FIXED = 6'h24;
    // command byte field positions
    localparam int CMD_START_BIT = 7;
    localparam int CMD_CH_TOP = 6;
    localparam int CMD_CH_MID = 5;
    localparam int CMD_CH_LOW = 4;
    localparam int CMD_PD_BIT = 2;
    localparam int CMD_RES_BIT = 1;
    // command in force after reset: accelerate command, auto power-down
    localparam logic [7:0] CMD_RESET = 8'h80;
    // reset value of the edge counters
    localparam logic [4:0] CNT_RESET = 5'h00;
endpackage

// File: design/tpps_touch_seq.sv
// touch-panel sequencer: scl edge timing, drivers, converter control, pen interrupt
`timescale 1ns/1ps
`default_nettype none

module tpps_touch_seq (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic sda_in,
    input wire logic addr_select_pin,
    input wire logic pen_touch_sense,
    input wire logic [11:0] adc_result,
    output logic sda_out,
    output logic sda_oe_n,
    output logic pen_touch_irq_n,
    output logic x_plus_plate_en,
    output logic x_minus_plate_en,
    output logic y_plus_plate_en,
    output logic y_minus_plate_en,
    output logic internal_pullup_en,
    output logic adc_power_en,
    output logic adc_sample_en,
    output logic adc_convert_en
);
    logic [1:0] rst_s_reg;
    logic rst_sync_n;
    logic rise_tgl_reg;
    logic fall_tgl_reg;
    logic link_bit_reg;
    logic [2:0] rise_s_reg;
    logic [2:0] fall_s_reg;
    logic [1:0] bit_s_reg;
    logic [3:0] sda_s_reg;
    logic [1:0] tch_s_reg;
    logic [1:0] adr_s_reg;
    logic scl_high_reg;
    logic rise_ev, fall_ev, start_ev, stop_ev;
    logic rise_hit, fall_hit;
    logic frame_reg;
    logic [4:0] rise_cnt_reg, fall_cnt_reg, rise_idx, fall_idx;
    logic [7:0] shift_reg, pend_reg, cmd_reg;
    logic addr_ok_reg, rd_reg, mack_reg;
    logic wr_ph, rd_ph, commit;
    logic phase4_reg, sample_reg, conv_reg, drv_on_reg;
    logic sda_oe_n_reg, irq_n_reg, irq_next;
    logic [3:0] drv_reg;
    logic pullup_reg, adc_pwr_reg, sda_out_reg;
    logic cmd_pd, cmd_top, cmd_s;

    // plate enables for a channel, ordered x_plus, x_minus, y_plus, y_minus
    function automatic logic [3:0] drv_pattern(input logic [1:0] ch);
        logic [3:0] p;
        p = 4'h6;
        unique case (ch)
            2'h0: p = 4'hC;
            2'h1: p = 4'h3;
            2'h2: p = 4'h6;
            2'h3: p = 4'h6;
        endcase
        return p;
    endfunction

    // result bit carried in the data slot that opens at falling edge idx
    function automatic logic tx_bit(input logic [4:0] idx, input logic [11:0] res,
                                    input logic mode8);
        logic [4:0] k;
        logic b;
        k = 5'h00;
        b = 1'b0;
        if (idx <= tpps_pkg::FALL_RD_HI_LAST)
        begin
            k = 5'h14 - idx;
            b = res[k[3:0]];
        end
        else if (idx <= 5'h15 && !mode8)
        begin
            k = 5'h15 - idx;
            b = res[k[3:0]];
        end
        return b;
    endfunction

    // reset release synchroniser, asserted at once, released after two edges
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_s_reg <= 2'h0;
        else
            rst_s_reg <= {rst_s_reg[0], 1'b1};
    end
    assign rst_sync_n = rst_s_reg[1];

    // link side: capture data and mark each rising scl edge
    always_ff @(posedge scl_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            rise_tgl_reg <= 1'b0;
            link_bit_reg <= 1'b0;
        end
        else
        begin
            rise_tgl_reg <= ~rise_tgl_reg;
            link_bit_reg <= sda_in;
        end
    end

    // link side: mark each falling scl edge
    always_ff @(negedge scl_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            fall_tgl_reg <= 1'b0;
        else
            fall_tgl_reg <= ~fall_tgl_reg;
    end

    // crossings; sda gets one extra stage so an scl fall is always seen before
    // a data change made right after it, which would otherwise mimic a start
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            rise_s_reg <= 3'h0;
            fall_s_reg <= 3'h0;
            bit_s_reg <= 2'h0;
            sda_s_reg <= 4'hF;
            tch_s_reg <= 2'h0;
            adr_s_reg <= 2'h0;
        end
        else
        begin
            rise_s_reg <= {rise_s_reg[1:0], rise_tgl_reg};
            fall_s_reg <= {fall_s_reg[1:0], fall_tgl_reg};
            bit_s_reg <= {bit_s_reg[0], link_bit_reg};
            sda_s_reg <= {sda_s_reg[2:0], sda_in};
            tch_s_reg <= {tch_s_reg[0], pen_touch_sense};
            adr_s_reg <= {adr_s_reg[0], addr_select_pin};
        end
    end

    assign rise_ev = rise_s_reg[2] ^ rise_s_reg[1];
    assign fall_ev = fall_s_reg[2] ^ fall_s_reg[1];
    assign start_ev = scl_high_reg && sda_s_reg[3] && !sda_s_reg[2];
    assign stop_ev = scl_high_reg && !sda_s_reg[3] && sda_s_reg[2];
    assign rise_idx = rise_cnt_reg + 5'h01;
    assign fall_idx = fall_cnt_reg + 5'h01;
    assign rise_hit = frame_reg && rise_ev && (rise_cnt_reg != tpps_pkg::CNT_MAX);
    // the fall that follows start is not a clock pulse and is not counted
    assign fall_hit = frame_reg && fall_ev && (fall_cnt_reg < rise_cnt_reg);
    assign wr_ph = frame_reg && addr_ok_reg && !rd_reg && (rise_cnt_reg >= tpps_pkg::RISE_RW);
    assign rd_ph = frame_reg && addr_ok_reg && rd_reg && (rise_cnt_reg >= tpps_pkg::RISE_RW);
    assign commit = fall_hit && wr_ph && (fall_idx == tpps_pkg::FALL_CMD);
    assign cmd_pd = cmd_reg[tpps_pkg::CMD_PD_BIT];
    assign cmd_top = cmd_reg[tpps_pkg::CMD_CH_TOP];
    assign cmd_s = cmd_reg[tpps_pkg::CMD_START_BIT];

    // scl level as seen through the crossings; bus idles high
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            scl_high_reg <= 1'b1;
        else if (rise_ev)
            scl_high_reg <= 1'b1;
        else if (fall_ev)
            scl_high_reg <= 1'b0;
    end

    // frame and edge counters; repeated start restarts the count
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            frame_reg <= 1'b0;
            rise_cnt_reg <= tpps_pkg::CNT_RESET;
            fall_cnt_reg <= tpps_pkg::CNT_RESET;
        end
        else if (start_ev)
        begin
            frame_reg <= 1'b1;
            rise_cnt_reg <= tpps_pkg::CNT_RESET;
            fall_cnt_reg <= tpps_pkg::CNT_RESET;
        end
        else if (stop_ev)
            frame_reg <= 1'b0;
        else
        begin
            if (rise_hit)
                rise_cnt_reg <= rise_idx;
            if (fall_hit)
                fall_cnt_reg <= fall_idx;
        end
    end

    // address match, direction, command byte and master acknowledge
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            shift_reg <= 8'h00;
            pend_reg <= tpps_pkg::CMD_RESET;
            addr_ok_reg <= 1'b0;
            rd_reg <= 1'b0;
            mack_reg <= 1'b0;
        end
        else if (start_ev)
        begin
            addr_ok_reg <= 1'b0;
            rd_reg <= 1'b0;
            mack_reg <= 1'b0;
        end
        else if (rise_hit)
        begin
            shift_reg <= {shift_reg[6:0], bit_s_reg[1]};
            if (rise_idx == tpps_pkg::RISE_ADDR)
                addr_ok_reg <= {shift_reg[5:0], bit_s_reg[1]}
                    == {tpps_pkg::ADDR_FIXED, adr_s_reg[1]};
            if (rise_idx == tpps_pkg::RISE_RW)
                rd_reg <= bit_s_reg[1];
            if (rise_idx == tpps_pkg::RISE_CMD_LAST)
                pend_reg <= {shift_reg[6:0], bit_s_reg[1]};
            if (rise_idx == tpps_pkg::RISE_MACK)
                mack_reg <= !bit_s_reg[1];
        end
    end

    // command in force; reset value keeps pen detection alive
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            cmd_reg <= tpps_pkg::CMD_RESET;
        else if (commit)
            cmd_reg <= pend_reg;
    end

    // span after a command write until the direction bit of the next addressed frame
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            phase4_reg <= 1'b0;
        else if (commit)
            phase4_reg <= 1'b1;
        else if (rise_hit && addr_ok_reg && rise_idx == tpps_pkg::RISE_RW)
            phase4_reg <= 1'b0;
    end

    // sampling starts before direction is known and is dropped on a write
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            sample_reg <= 1'b0;
        else if (start_ev || stop_ev)
            sample_reg <= 1'b0;
        else if (fall_hit && addr_ok_reg && fall_idx == tpps_pkg::FALL_SAMPLE)
            sample_reg <= 1'b1;
        else if (rise_hit && rise_idx == tpps_pkg::RISE_RW && !bit_s_reg[1])
            sample_reg <= 1'b0;
        else if (fall_hit && fall_idx == tpps_pkg::FALL_CONV)
            sample_reg <= 1'b0;
    end

    // conversion spans falls 8 to 21, thirteen periods with the master ack
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            conv_reg <= 1'b0;
        else if (start_ev || stop_ev)
            conv_reg <= 1'b0;
        else if (fall_hit && rd_ph && fall_idx == tpps_pkg::FALL_CONV)
            conv_reg <= 1'b1;
        else if (fall_hit && fall_idx == tpps_pkg::FALL_CONV_END)
            conv_reg <= 1'b0;
    end

    // plates held on after a command write: accelerate, or pd 1; the end of a read drops them unless pd is 1
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            drv_on_reg <= 1'b0;
        else if (commit)
            drv_on_reg <= pend_reg[tpps_pkg::CMD_START_BIT]
                && (!pend_reg[tpps_pkg::CMD_CH_TOP] || pend_reg[tpps_pkg::CMD_PD_BIT]);
        else if (fall_hit && rd_ph && fall_idx == tpps_pkg::FALL_CONV_END && !cmd_pd)
            drv_on_reg <= 1'b0;
    end

    // open-drain data: only ever pulls low; result is read bit by bit as the
    // successive approximation settles, so each bit is taken as it is sent
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            sda_oe_n_reg <= 1'b1;
        else if (start_ev || stop_ev)
            sda_oe_n_reg <= 1'b1;
        else if (fall_hit)
        begin
            if (fall_idx == tpps_pkg::FALL_ADDR_ACK)
                sda_oe_n_reg <= !addr_ok_reg;
            else if (rd_ph && ((fall_idx >= tpps_pkg::FALL_RD_HI_FIRST
                     && fall_idx <= tpps_pkg::FALL_RD_HI_LAST)
                     || (mack_reg && fall_idx >= tpps_pkg::FALL_RD_LO_FIRST
                     && fall_idx <= tpps_pkg::FALL_RD_LO_LAST)))
                sda_oe_n_reg <= tx_bit(fall_idx, adc_result,
                                       cmd_reg[tpps_pkg::CMD_RES_BIT]);
            else if (wr_ph && fall_idx == tpps_pkg::FALL_WR_ACK)
                sda_oe_n_reg <= 1'b0;
            else
                sda_oe_n_reg <= 1'b1;
        end
    end

    // pen interrupt phases; cmd_reg is still the previous command before fall 18
    always_comb
    begin
        if (frame_reg && addr_ok_reg && fall_cnt_reg >= tpps_pkg::FALL_SAMPLE
            && rise_cnt_reg < tpps_pkg::RISE_RW)
            irq_next = 1'b0;
        else if (rd_ph && fall_cnt_reg >= tpps_pkg::FALL_SAMPLE
                 && fall_cnt_reg < tpps_pkg::FALL_CONV_END)
            irq_next = 1'b0;
        else if (phase4_reg)
            irq_next = (cmd_top || cmd_pd) ? 1'b0 : !tch_s_reg[1];
        else
            irq_next = cmd_pd ? 1'b0 : !tch_s_reg[1];
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            irq_n_reg <= 1'b1;
        else
            irq_n_reg <= irq_next;
    end

    // plate drivers, pull-up and converter power
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            drv_reg <= 4'h1;
            pullup_reg <= 1'b1;
            adc_pwr_reg <= 1'b0;
            sda_out_reg <= 1'b0;
        end
        else
        begin
            sda_out_reg <= 1'b0;
            adc_pwr_reg <= sample_reg || conv_reg || (cmd_pd && cmd_s && drv_on_reg);
            if (cmd_s && (drv_on_reg || sample_reg || conv_reg))
            begin
                drv_reg <= drv_pattern(cmd_reg[tpps_pkg::CMD_CH_MID:tpps_pkg::CMD_CH_LOW]);
                pullup_reg <= 1'b0;
            end
            else if (cmd_s)
            begin
                drv_reg <= 4'h1;
                pullup_reg <= 1'b1;
            end
            else
            begin
                drv_reg <= 4'h0; // sleep command: panel open
                pullup_reg <= 1'b0;
            end
        end
    end

    assign sda_out = sda_out_reg;
    assign sda_oe_n = sda_oe_n_reg;
    assign pen_touch_irq_n = irq_n_reg;
    assign x_plus_plate_en = drv_reg[3];
    assign x_minus_plate_en = drv_reg[2];
    assign y_plus_plate_en = drv_reg[1];
    assign y_minus_plate_en = drv_reg[0];
    assign internal_pullup_en = pullup_reg;
    assign adc_power_en = adc_pwr_reg;
    assign adc_sample_en = sample_reg;
    assign adc_convert_en = conv_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    a_sample_window: assert property (sample_reg |-> fall_cnt_reg == tpps_pkg::FALL_SAMPLE)
        else $error("sampling outside falls 7 to 8");
    a_conv_span: assert property (conv_reg |-> rd_reg && fall_cnt_reg >= tpps_pkg::FALL_CONV
        && fall_cnt_reg < tpps_pkg::FALL_CONV_END)
        else $error("conversion outside falls 8 to 21");
    a_irq_conv_low: assert property (rd_ph && fall_cnt_reg >= tpps_pkg::FALL_SAMPLE
        && fall_cnt_reg < tpps_pkg::FALL_CONV_END |=> !pen_touch_irq_n)
        else $error("pen irq high during conversion");
    a_irq_write_low: assert property (frame_reg && addr_ok_reg && !rd_reg
        && fall_cnt_reg >= tpps_pkg::FALL_SAMPLE && rise_cnt_reg < tpps_pkg::RISE_RW
        |=> !pen_touch_irq_n)
        else $error("pen irq high in write mask window");
    a_irq_pd_low: assert property (cmd_pd && !frame_reg |=> !pen_touch_irq_n)
        else $error("pen irq high with pd set");
    a_irq_touch: assert property (!frame_reg && !phase4_reg && !cmd_pd
        |=> pen_touch_irq_n == !$past(tch_s_reg[1]))
        else $error("pen irq does not follow touch");
    a_accel_on: assert property (commit && pend_reg[tpps_pkg::CMD_START_BIT]
        && !pend_reg[tpps_pkg::CMD_CH_TOP] |=> ##1 drv_reg != 4'h1 && !internal_pullup_en)
        else $error("accelerate drivers not on after fall 18");
    a_yn_idle: assert property (cmd_s && !drv_on_reg && !sample_reg && !conv_reg
        |=> y_minus_plate_en && !x_plus_plate_en && !x_minus_plate_en && !y_plus_plate_en)
        else $error("idle plates not grounded on y minus only");
    a_adc_off: assert property (!cmd_pd && !sample_reg && !conv_reg |=> !adc_power_en)
        else $error("converter powered outside conversion");
    a_addr_ack: assert property (fall_hit && fall_idx == tpps_pkg::FALL_ADDR_ACK && addr_ok_reg
        |=> !sda_oe_n)
        else $error("no acknowledge of matching address");
    a_cmd_commit: assert property (commit |=> cmd_reg == $past(pend_reg))
        else $error("command not taken at fall 18");

    c_write_cmd: cover property (commit);
    c_read_done: cover property (rd_ph && fall_hit && fall_idx == tpps_pkg::FALL_CONV_END);
    c_second_byte: cover property (rd_ph && mack_reg && fall_hit
        && fall_idx == tpps_pkg::FALL_RD_LO_FIRST);
    c_touch_irq: cover property (!frame_reg && !pen_touch_irq_n && !cmd_pd);
endmodule

`default_nettype wire

// File: bench/tpps_host_model.sv
// behavioural host: i2c bus master making scl and pulling the open-drain sda
`timescale 1ns/1ps
`default_nettype none

module tpps_host_model (
    input wire logic sda_wire,
    output logic scl_clk,
    output logic sda_pull
);
    // scl low 48 ns, high 32 ns; the device answers up to 40 ns after a fall
    localparam int T_SET = 8;
    localparam int T_LOW = 40;
    localparam int T_HIGH = 32;
    // each frame opens half a clk period off the clk edges, as an unrelated host
    // would, so no scl or sda edge races a clk sampling edge
    localparam int T_SKEW = 4;

    // released bus, scl stands high between frames; no pen interrupt input, so
    // false pulses during commands and results never disturb the host
    initial
    begin
        scl_clk = 1'h1;
        sda_pull = 1'h0;
    end

    // start or repeated start: sda falls while scl is high
    task automatic start_cond();
        #(T_SET + T_SKEW) sda_pull = 1'h0;
        #(T_LOW) scl_clk = 1'h1;
        #(T_LOW) sda_pull = 1'h1;
        #(T_LOW) scl_clk = 1'h0;
    endtask

    // stop: sda rises while scl is high, then the bus idles
    task automatic stop_cond();
        #(T_SET) sda_pull = 1'h1;
        #(T_LOW) scl_clk = 1'h1;
        #(T_LOW) sda_pull = 1'h0;
        #(T_LOW);
    endtask

    // one bit: data changes only while scl is low, sampled at the rise
    task automatic clock_bit(input logic b, output logic seen);
        #(T_SET) sda_pull = ~b;
        #(T_LOW) scl_clk = 1'h1;
        seen = sda_wire;
        #(T_HIGH) scl_clk = 1'h0;
    endtask

    // byte out msb first, then the device's acknowledge (0 = acked)
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(b[i], s);
        clock_bit(1'h1, ack);
    endtask

    // byte in msb first, then ack or nack from the host
    task automatic get_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            clock_bit(1'h1, b[i]);
        clock_bit(~give_ack, s);
    endtask
endmodule

`default_nettype wire

// File: bench/tb_touch_adc_power_pen_sequencer.sv
// self-checking bench of the touch-panel power and pen sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_touch_adc_power_pen_sequencer;
    typedef struct packed {
        logic [7:0] cmd;
        logic touch;
        logic [3:0] plates;
        logic irq_n;
    } tpps_row_s;

    logic clk, rst_n, touch, pin, scl, sda_pull, sda_wire, sda_oe_n, irq_n;
    logic xp, xn, yp, yn, pwr, samp, conv, pu, sda_lvl;
    logic conv_d = 1'h0;
    logic [11:0] adc_val;
    logic [3:0] plates;
    logic a;
    int n_errors = 0;
    int samples_checked = 0;
    // activity counters, written by the monitor process only
    int n_samp = 0;
    int n_conv = 0;
    int n_irq_bad = 0;
    // plates after a write, in order x+, x-, y+, y
    tpps_row_s rows [10] = '{'{8'h80, 1'h0, 4'hC, 1'h1}, '{8'h90, 1'h1, 4'h3, 1'h0},
        '{8'hA0, 1'h0, 4'h6, 1'h1}, '{8'hB0, 1'h1, 4'h6, 1'h0}, '{8'h84, 1'h0, 4'hC, 1'h0},
        '{8'hC4, 1'h0, 4'hC, 1'h0}, '{8'hD4, 1'h0, 4'h3, 1'h0}, '{8'hC0, 1'h0, 4'h1, 1'h0},
        '{8'hE0, 1'h0, 4'h1, 1'h0}, '{8'hF0, 1'h0, 4'h1, 1'h0}};

    // open drain: either party pulling wins, else the pull-up
    assign sda_wire = ~(sda_pull | ~sda_oe_n);
    assign plates = {xp, xn, yp, yn};

    tpps_touch_seq DUT (
        .clk(clk), .rst_n(rst_n), .scl_clk(scl), .sda_in(sda_wire),
        .addr_select_pin(pin), .pen_touch_sense(touch), .adc_result(adc_val),
        .sda_out(sda_lvl), .sda_oe_n(sda_oe_n), .pen_touch_irq_n(irq_n),
        .x_plus_plate_en(xp), .x_minus_plate_en(xn), .y_plus_plate_en(yp),
        .y_minus_plate_en(yn), .internal_pullup_en(pu), .adc_power_en(pwr),
        .adc_sample_en(samp), .adc_convert_en(conv)
    );

    tpps_host_model host (.sda_wire(sda_wire), .scl_clk(scl), .sda_pull(sda_pull));

    always #4 clk = ~clk;

    // running counts; irq is judged only once conversion has settled a cycle
    always @(posedge clk)
    begin
        conv_d <= conv;
        if (samp === 1'h1) n_samp <= n_samp + 1;
        if (conv === 1'h1) n_conv <= n_conv + 1;
        if (conv_d === 1'h1 && conv === 1'h1 && irq_n !== 1'h0) n_irq_bad <= n_irq_bad + 1;
    end

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // write one command byte, then let the new drivers settle
    task automatic wr_cmd(input logic [7:0] cmd);
        host.start_cond();
        host.put_byte({6'h24, pin, 1'h0}, a);
        check_bit("write address ack", 1'h0, a);
        host.put_byte(cmd, a);
        check_bit("command ack", 1'h0, a);
        host.stop_cond();
        repeat (8) @(posedge clk);
    endtask

    // one read with a fresh converter value
    task automatic rd_result(input logic [11:0] val, input logic mode8);
        logic [7:0] b;
        int samp_0;
        int conv_0;
        @(posedge clk) adc_val <= val;
        samp_0 = n_samp;
        conv_0 = n_conv;
        host.start_cond();
        host.put_byte({6'h24, pin, 1'h1}, a);
        check_bit("read address ack", 1'h0, a);
        host.get_byte(~mode8, b);
        check_byte("high byte", val[11:4], b);
        if (!mode8)
        begin
            host.get_byte(1'h0, b);
            check_byte("low byte", {val[3:0], 4'h0}, b);
        end
        host.stop_cond();
        repeat (8) @(posedge clk);
        check_bit("sample window", 1'h1, n_samp > samp_0);
        check_bit("convert window", 1'h1, n_conv > conv_0);
        check_bit("irq in conversion", 1'h0, n_irq_bad != 0);
    endtask

    // bound on the whole run
    initial
    begin
        repeat (100000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial
    begin
        clk = 1'h0;
        rst_n = 1'h0;
        touch = 1'h0;
        pin = 1'h1;
        adc_val = 12'h000;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        repeat (6) @(posedge clk);
        check_bit("irq after reset", 1'h1, irq_n);
        check_byte("plates after reset", 8'h01, {4'h0, plates});
        check_bit("sda after reset", 1'h1, sda_oe_n);
        check_bit("sda out level", 1'h0, sda_lvl);
        check_bit("pullup after reset", 1'h1, pu);
        @(posedge clk) touch <= 1'h1;
        repeat (6) @(posedge clk);
        check_bit("irq on touch", 1'h0, irq_n);
        @(posedge clk) touch <= 1'h0;
        repeat (6) @(posedge clk);
        check_bit("irq on release", 1'h1, irq_n);
        foreach (rows[i])
        begin
            @(posedge clk) touch <= rows[i].touch;
            wr_cmd(rows[i].cmd);
            check_byte("plates", {4'h0, rows[i].plates}, {4'h0, plates});
            check_bit("irq after write", rows[i].irq_n, irq_n);
        end
        @(posedge clk) touch <= 1'h0;
        // x-axis reads, auto power-down then converter kept on
        for (int pd = 0; pd < 2; pd++)
        begin
            wr_cmd({4'hC, 1'h0, pd[0], 2'h0});
            rd_result(12'hA5C, 1'h0);
            rd_result(12'h3E1, 1'h0);
            check_bit("irq after read", pd == 0, irq_n);
            check_bit("adc power after read", pd == 1, pwr);
            check_byte("plates after read", pd == 0 ? 8'h01 : 8'h0C, {4'h0, plates});
            check_bit("pullup after read", pd == 0, pu);
        end
        wr_cmd(8'hC2);
        rd_result(12'h7B4, 1'h1);
        // foreign address is left unanswered
        host.start_cond();
        host.put_byte({6'h24, ~pin, 1'h0}, a);
        check_bit("foreign address ack", 1'h1, a);
        host.stop_cond();
        @(posedge clk) pin <= 1'h0;
        repeat (6) @(posedge clk);
        wr_cmd(8'hC0);
        complete_run();
    end
endmodule

`default_nettype wire
